// >>> rtl/qdt_edge_sel.sv
// Source selector with edge detection for one comparator input.
// Assumes comparator outputs synchronous to clk_i.
`timescale 1ns/10ps
`include "qdt_map.svh"
module qdt_edge_sel (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`QDT_NSRC-1:0] comp_i,
   input wire logic [2:0] sel_i,
   output logic lvl_o,
   output logic rise_o,
   output logic fall_o
);
   qdt_pkg::qdt_edge_s s;
   qdt_pkg::qdt_edge_s next_s;

   // Pick one of the four channels or the two external inputs
   always_comb begin
      next_s.prev = s.lvl;
      next_s.lvl = (sel_i < 3'h6) ? comp_i[sel_i] : 1'b0;
   end

   // Register level and its previous value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Edges seen in the same cycle as the sampled level
   assign lvl_o = s.lvl;
   assign rise_o = s.lvl & ~s.prev;
   assign fall_o = ~s.lvl & s.prev;
endmodule

// >>> rtl/qdt_map.svh
// Register map, field positions, reset values and timing counts of the trigger block.
// Assumes a 50 MHz clock; counts are derived from the printed times.
`ifndef QDT_MAP_SVH
`define QDT_MAP_SVH

// Word offsets on the Wishbone bus (byte addresses)
`define QDT_ADR_CTRL 8'h00
`define QDT_ADR_QTIME 8'h04
`define QDT_ADR_QEVS 8'h08
`define QDT_ADR_DTIME 8'h0C
`define QDT_ADR_STAT 8'h10

// Control register fields
`define QDT_CTRL_MODE 0
`define QDT_CTRL_BY_EDGE 2
`define QDT_CTRL_BELOW 3
`define QDT_CTRL_WAIT 4
`define QDT_CTRL_DNEG 6
`define QDT_CTRL_TSRC 8
`define QDT_CTRL_QSRC 12

// Status register fields
`define QDT_STAT_ARMED 0
`define QDT_STAT_DARMED 1
`define QDT_STAT_QLVL 2
`define QDT_STAT_FCNT 16

// Counter width and number of selectable sources
`define QDT_CNT_W 30
`define QDT_NSRC 6

// Clock rate, time limits and event count limits
`define QDT_CLK_MHZ 50
`define QDT_QT_MIN_NS 10
`define QDT_QT_MAX_S 20
`define QDT_DT_MIN_NS 25
`define QDT_DT_MAX_S 20
`define QDT_EVS_MIN 1
`define QDT_EVS_MAX 1000000000

// Least times round up, longest times round down, never under one cycle
`define QDT_NS2CYC_UP(ns) (((ns) * `QDT_CLK_MHZ + 999) / 1000)
`define QDT_QT_MIN_CYC `QDT_NS2CYC_UP(`QDT_QT_MIN_NS)
`define QDT_QT_MAX_CYC (`QDT_QT_MAX_S * `QDT_CLK_MHZ * 1000000)
`define QDT_DT_MIN_CYC `QDT_NS2CYC_UP(`QDT_DT_MIN_NS)
`define QDT_DT_MAX_CYC (`QDT_DT_MAX_S * `QDT_CLK_MHZ * 1000000)

`endif

// >>> rtl/qdt_pkg.sv
// Types shared by the trigger block: modes, wait options and state records.
// Assumes the map header for counter width.
`include "qdt_map.svh"
package qdt_pkg;

   // Trigger mode; code 3 is illegal and behaves as off
   typedef enum logic [1:0] {QDT_M_OFF, QDT_M_QUAL, QDT_M_DROP} qdt_mode_e;

   // Wait option of the qualified trigger
   typedef enum logic [1:0] {QDT_W_OFF, QDT_W_TLT, QDT_W_TGT, QDT_W_EVS} qdt_wait_e;

   typedef logic [`QDT_CNT_W-1:0] qdt_cnt_t;

   // Source selector state
   typedef struct packed {
      logic lvl;
      logic prev;
   } qdt_edge_s;

   // Whole state of the trigger core
   typedef struct packed {
      qdt_mode_e mode;
      logic by_edge;
      logic below;
      qdt_wait_e wmode;
      logic dneg;
      logic [2:0] tsrc;
      logic [2:0] qsrc;
      qdt_cnt_t tval;
      qdt_cnt_t evs;
      qdt_cnt_t dto;
      logic ack;
      logic [31:0] rdat;
      logic armed;
      qdt_cnt_t elapsed;
      qdt_cnt_t events;
      logic darmed;
      qdt_cnt_t dcnt;
      logic trig;
      logic [15:0] fcnt;
   } qdt_core_s;

endpackage

// >>> rtl/qdt_trigger.sv
// Qualified and dropout trigger core with its Wishbone register slave.
// Assumes comparator outputs synchronous to clk_i and a classic Wishbone master.
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "qdt_map.svh"
// How it works
// - State mode: trigger only while qualifier valid
// - State mode: invalid qualifier clears both counters
// - Edge mode: one crossing validates, no holding
// - Edge mode: each validating crossing restarts both counters
// - Wait off: first event after validation fires
// - T< wait: accept only before limit
// - T> wait: reject until delay, then fire
// - Evs wait: skip count events, fire next
// - Qualify time spans 10 ns to 20 s
// - Event count spans one to one billion
// - Control bit picks above or below threshold
// - Trigger, qualifier sources each pick six inputs
// - Dropout fires when no selected edge timeout
// - Dropout fires at expiry; edges restart it
// - Dropout bit picks positive or negative slope
// - Dropout timeout spans 25 ns to 20 s
module qdt_trigger #(
   parameter int unsigned QT_MAX_CYC = `QDT_QT_MAX_CYC,
   parameter int unsigned DT_MAX_CYC = `QDT_DT_MAX_CYC,
   parameter int unsigned EVS_MAX = `QDT_EVS_MAX
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [`QDT_NSRC-1:0] comp_i,
   output logic trig_o
);
   localparam int unsigned QT_MIN = `QDT_QT_MIN_CYC;
   localparam int unsigned DT_MIN = `QDT_DT_MIN_CYC;
   localparam int unsigned EV_MIN = `QDT_EVS_MIN;

   qdt_pkg::qdt_core_s s;
   qdt_pkg::qdt_core_s next_s;
   logic t_rise;
   logic t_fall;
   logic q_raw;
   logic q_rise;
   logic q_fall;
   logic q_lvl;
   logic val_ev;
   logic trig_ev;
   logic d_ev;
   logic bus_req;
   logic [31:0] wd;
   logic [31:0] ctrl_rd;
   logic [31:0] stat_rd;
   logic q_hold;

   // Limit a written value to the supported range
   function automatic qdt_pkg::qdt_cnt_t clamp(input logic [31:0] v, input int unsigned lo,
                                               input int unsigned hi);
      if (v < lo) begin
         return lo[`QDT_CNT_W-1:0];
      end else if (v > hi) begin
         return hi[`QDT_CNT_W-1:0];
      end
      return v[`QDT_CNT_W-1:0];
   endfunction

   // Merge write data into the old word by byte lane
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Trigger source selector, also the dropout source
   qdt_edge_sel u_tsel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .comp_i(comp_i),
      .sel_i(s.tsrc),
      .lvl_o(),
      .rise_o(t_rise),
      .fall_o(t_fall)
   );

   // Qualifier source selector
   qdt_edge_sel u_qsel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .comp_i(comp_i),
      .sel_i(s.qsrc),
      .lvl_o(q_raw),
      .rise_o(q_rise),
      .fall_o(q_fall)
   );

   // Qualifier side, validation event, trigger and dropout edges
   assign q_lvl = q_raw ^ s.below;
   assign val_ev = s.below ? q_fall : q_rise;
   assign trig_ev = t_rise;
   assign d_ev = s.dneg ? t_fall : t_rise;
   assign bus_req = cyc_i & stb_i & ~s.ack;
   assign q_hold = (s.mode == qdt_pkg::QDT_M_QUAL) & (s.by_edge | q_lvl) & ~val_ev;

   // Readable words of control and status
   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[`QDT_CTRL_MODE +: 2] = s.mode;
      ctrl_rd[`QDT_CTRL_BY_EDGE] = s.by_edge;
      ctrl_rd[`QDT_CTRL_BELOW] = s.below;
      ctrl_rd[`QDT_CTRL_WAIT +: 2] = s.wmode;
      ctrl_rd[`QDT_CTRL_DNEG] = s.dneg;
      ctrl_rd[`QDT_CTRL_TSRC +: 3] = s.tsrc;
      ctrl_rd[`QDT_CTRL_QSRC +: 3] = s.qsrc;
      stat_rd = '0;
      stat_rd[`QDT_STAT_ARMED] = s.armed;
      stat_rd[`QDT_STAT_DARMED] = s.darmed;
      stat_rd[`QDT_STAT_QLVL] = q_lvl;
      stat_rd[`QDT_STAT_FCNT +: 16] = s.fcnt;
   end

   // Next state: bus slave, qualified sequence, dropout timer
   always_comb begin
      next_s = s;
      next_s.trig = 1'b0;
      next_s.ack = bus_req;
      wd = '0;
      if (bus_req) begin
         unique case (adr_i)
            `QDT_ADR_CTRL: begin
               next_s.rdat = ctrl_rd;
               wd = merge(ctrl_rd, dat_i, sel_i);
            end
            `QDT_ADR_QTIME: begin
               next_s.rdat = {2'h0, s.tval};
               wd = merge({2'h0, s.tval}, dat_i, sel_i);
            end
            `QDT_ADR_QEVS: begin
               next_s.rdat = {2'h0, s.evs};
               wd = merge({2'h0, s.evs}, dat_i, sel_i);
            end
            `QDT_ADR_DTIME: begin
               next_s.rdat = {2'h0, s.dto};
               wd = merge({2'h0, s.dto}, dat_i, sel_i);
            end
            `QDT_ADR_STAT: next_s.rdat = stat_rd;
            default: next_s.rdat = '0;
         endcase
         if (we_i) begin
            unique case (adr_i)
               `QDT_ADR_CTRL: begin
                  next_s.mode = qdt_pkg::qdt_mode_e'(wd[`QDT_CTRL_MODE +: 2]);
                  next_s.by_edge = wd[`QDT_CTRL_BY_EDGE];
                  next_s.below = wd[`QDT_CTRL_BELOW];
                  next_s.wmode = qdt_pkg::qdt_wait_e'(wd[`QDT_CTRL_WAIT +: 2]);
                  next_s.dneg = wd[`QDT_CTRL_DNEG];
                  next_s.tsrc = wd[`QDT_CTRL_TSRC +: 3];
                  next_s.qsrc = wd[`QDT_CTRL_QSRC +: 3];
               end
               `QDT_ADR_QTIME: next_s.tval = clamp(wd, QT_MIN, QT_MAX_CYC);
               `QDT_ADR_QEVS: next_s.evs = clamp(wd, EV_MIN, EVS_MAX);
               `QDT_ADR_DTIME: next_s.dto = clamp(wd, DT_MIN, DT_MAX_CYC);
               default: ;
            endcase
         end
      end

      // Qualified trigger sequence
      if (s.mode != qdt_pkg::QDT_M_QUAL) begin
         next_s.armed = 1'b0;
      end else if (!s.by_edge && !q_lvl) begin
         next_s.armed = 1'b0;
         next_s.elapsed = '0;
         next_s.events = '0;
      end else if (val_ev) begin
         next_s.armed = 1'b1;
         next_s.elapsed = '0;
         next_s.events = '0;
      end else if (s.armed) begin
         if (s.elapsed != '1) begin
            next_s.elapsed = s.elapsed + 1'b1;
         end
         unique case (s.wmode)
            qdt_pkg::QDT_W_OFF: begin
               if (trig_ev) begin
                  next_s.trig = 1'b1;
               end
            end
            qdt_pkg::QDT_W_TLT: begin
               if (s.elapsed >= s.tval) begin
                  next_s.armed = 1'b0;
               end else if (trig_ev) begin
                  next_s.trig = 1'b1;
               end
            end
            qdt_pkg::QDT_W_TGT: begin
               if (trig_ev && s.elapsed >= s.tval) begin
                  next_s.trig = 1'b1;
               end
            end
            qdt_pkg::QDT_W_EVS: begin
               if (trig_ev && s.events >= s.evs) begin
                  next_s.trig = 1'b1;
               end else if (trig_ev) begin
                  next_s.events = s.events + 1'b1;
               end
            end
         endcase
         if (next_s.trig) begin
            next_s.armed = 1'b0;
         end
      end

      // Dropout timer, restarted by each selected edge
      if (s.mode != qdt_pkg::QDT_M_DROP) begin
         next_s.darmed = 1'b0;
         next_s.dcnt = '0;
      end else if (d_ev) begin
         next_s.darmed = 1'b1;
         next_s.dcnt = '0;
      end else if (s.darmed) begin
         if (s.dcnt + 1'b1 >= s.dto) begin
            next_s.trig = 1'b1;
            next_s.darmed = 1'b0;
         end else begin
            next_s.dcnt = s.dcnt + 1'b1;
         end
      end

      if (next_s.trig) begin
         next_s.fcnt = s.fcnt + 16'h0001;
      end
   end

   // State register with reset values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.tval <= QT_MIN[`QDT_CNT_W-1:0];
         s.evs <= EV_MIN[`QDT_CNT_W-1:0];
         s.dto <= DT_MIN[`QDT_CNT_W-1:0];
      end else begin
         s <= next_s;
      end
   end

   // Bus answer and trigger output
   assign dat_o = s.rdat;
   assign ack_o = s.ack;
   assign trig_o = s.trig;

   // Checks on the trigger sequence
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_state_drop;
      s.mode == qdt_pkg::QDT_M_QUAL && !s.by_edge && !q_lvl
         |=> !s.armed && s.elapsed == '0 && s.events == '0 && !trig_o;
   endproperty
   a_state_drop: assert property (p_state_drop) else $error("state qualifier loss kept armed");

   property p_valid_restart;
      s.mode == qdt_pkg::QDT_M_QUAL && val_ev && (s.by_edge || q_lvl)
         |=> s.armed && s.elapsed == '0 && s.events == '0;
   endproperty
   a_valid_restart: assert property (p_valid_restart) else $error("validation did not restart");

   property p_off_fire;
      q_hold && s.armed && s.wmode == qdt_pkg::QDT_W_OFF && trig_ev |=> trig_o ##1 !trig_o;
   endproperty
   a_off_fire: assert property (p_off_fire) else $error("immediate trigger missed");

   property p_tlt_close;
      q_hold && s.armed && s.wmode == qdt_pkg::QDT_W_TLT && s.elapsed >= s.tval
         |=> !trig_o && !s.armed;
   endproperty
   a_tlt_close: assert property (p_tlt_close) else $error("late event accepted");

   property p_tgt_early;
      q_hold && s.armed && s.wmode == qdt_pkg::QDT_W_TGT && s.elapsed < s.tval |=> !trig_o;
   endproperty
   a_tgt_early: assert property (p_tgt_early) else $error("early event accepted");

   property p_evs_count;
      q_hold && s.armed && s.wmode == qdt_pkg::QDT_W_EVS && trig_ev && s.events < s.evs
         |=> !trig_o && s.events == $past(s.events) + 1'b1;
   endproperty
   a_evs_count: assert property (p_evs_count) else $error("event count wrong");

   property p_no_refire;
      trig_o && s.mode == qdt_pkg::QDT_M_QUAL |-> !s.armed;
   endproperty
   a_no_refire: assert property (p_no_refire) else $error("still armed after trigger");

   property p_drop_fire;
      s.mode == qdt_pkg::QDT_M_DROP && s.darmed && !d_ev && s.dcnt + 1'b1 == s.dto
         |=> trig_o && !s.darmed;
   endproperty
   a_drop_fire: assert property (p_drop_fire) else $error("dropout not at expiry");

   property p_drop_restart;
      s.mode == qdt_pkg::QDT_M_DROP && d_ev |=> s.darmed && s.dcnt == '0 && !trig_o;
   endproperty
   a_drop_restart: assert property (p_drop_restart) else $error("edge did not restart");

   property p_limits;
      s.tval >= QT_MIN && s.tval <= QT_MAX_CYC && s.dto >= DT_MIN && s.dto <= DT_MAX_CYC
         && s.evs >= EV_MIN && s.evs <= EVS_MAX;
   endproperty
   a_limits: assert property (p_limits) else $error("setting out of range");

   c_qual_fire: cover property (s.mode == qdt_pkg::QDT_M_QUAL && trig_o);
   c_evs_fire: cover property (s.wmode == qdt_pkg::QDT_W_EVS && s.armed && trig_ev ##1 trig_o);
   c_tlt_close: cover property (s.wmode == qdt_pkg::QDT_W_TLT && s.armed ##1 !s.armed);
   c_drop_fire: cover property (s.mode == qdt_pkg::QDT_M_DROP && trig_o);
endmodule

// >>> sim/qdt_comp_model.sv
// Comparator outputs of the four channels and the two external inputs.
// Assumes the bench requests levels; each output follows one clock later.
`timescale 1ns/10ps
module qdt_comp_model (
   input wire logic clk_i,
   input wire logic [5:0] lvl_i,
   output logic [5:0] comp_o
);
   // Comparator decision registered on the sample clock, so edges are synchronous
   always_ff @(posedge clk_i) begin
      comp_o <= lvl_i;
   end
endmodule

// >>> sim/test_qdt_trigger.sv
// Self-checking bench of the qualified and dropout trigger core.
// Assumes shortened maximum counts of 64 and the comparator model in front of comp_i.
`timescale 1ns/10ps
`include "qdt_map.svh"
module test_qdt_trigger;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, trig_o;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [5:0] lvl, comp;
   int fail_count, n_compared, hit;
   localparam int DT = 10;

   // Design with short maxima and the comparator model feeding it
   qdt_trigger #(.QT_MAX_CYC(64), .DT_MAX_CYC(64), .EVS_MAX(64)) i_qdt_trigger (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .comp_i(comp), .trig_o(trig_o));
   qdt_comp_model i_qdt_comp_model (.clk_i(clk_i), .lvl_i(lvl), .comp_o(comp));

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Verdict and end of run
   task finish_test();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Classic single Wishbone cycle; holds the request until ack is sampled, the watchdog ends a hang
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Edge index (1..n) at which the trigger pulse is first sampled, 0 if none
   task watch(input int n);
      hit = 0;
      for (int i = 1; i <= n; i++) begin
         @(posedge clk_i);
         if (trig_o === 1'b1 && hit == 0) hit = i;
      end
   endtask

   // One rising edge on a source; immediate acceptance is seen at edge 4
   task shot(input int s, input int exp);
      lvl[s] <= 1'b1;
      watch(8);
      chk(hit, exp);
      lvl[s] <= 1'b0;
      @(posedge clk_i);
   endtask

   function automatic logic [31:0] cf(input int m, e, b, w, t, q);
      return 32'(m | e << 2 | b << 3 | w << 4 | t << 8 | q << 12);
   endfunction

   task setup(input logic [31:0] ctrl);
      lvl <= 6'h00;
      wb(1'b1, `QDT_ADR_CTRL, 32'h0);
      wb(1'b1, `QDT_ADR_CTRL, ctrl);
   endtask

   task t_regs();
      rdchk(`QDT_ADR_CTRL, 32'h0);
      rdchk(`QDT_ADR_QTIME, 32'h1);
      rdchk(`QDT_ADR_QEVS, 32'h1);
      rdchk(`QDT_ADR_DTIME, 32'h2);
      rdchk(8'h14, 32'h0);
      rdchk(`QDT_ADR_STAT, 32'h0);
      wb(1'b1, `QDT_ADR_QTIME, 32'h0);
      rdchk(`QDT_ADR_QTIME, 32'h1);
      wb(1'b1, `QDT_ADR_QEVS, 32'h3FFFFFFF);
      rdchk(`QDT_ADR_QEVS, 32'h40);
      // Low byte lane only: the upper bytes keep their old value
      sel_i <= 4'h1;
      wb(1'b1, `QDT_ADR_QEVS, 32'hFFFFFF05);
      sel_i <= 4'hF;
      rdchk(`QDT_ADR_QEVS, 32'h5);
      wb(1'b1, `QDT_ADR_DTIME, 32'h0);
      rdchk(`QDT_ADR_DTIME, 32'h2);
   endtask

   // Every source as qualifier and as trigger, wait off
   task t_immediate();
      for (int s = 0; s < 6; s++) begin
         setup(cf(1, 0, 0, 0, (s + 1) % 6, s));
         lvl[s] <= 1'b1;
         watch(3);
         shot((s + 1) % 6, 4);
         shot((s + 1) % 6, 0);
      end
   endtask

   task t_state_drop();
      setup(cf(1, 0, 0, 0, 0, 4));
      lvl[4] <= 1'b1;
      watch(3);
      lvl[4] <= 1'b0;
      watch(4);
      shot(0, 0);
   endtask

   // Limit of 5 cycles: gap 5 accepted, gap 6 refused
   task t_tlimit();
      wb(1'b1, `QDT_ADR_QTIME, 32'h5);
      setup(cf(1, 0, 0, 1, 0, 4));
      lvl[4] <= 1'b1;
      watch(5);
      shot(0, 4);
      lvl[4] <= 1'b0;
      watch(3);
      lvl[4] <= 1'b1;
      watch(6);
      shot(0, 0);
   endtask

   task t_tdelay();
      setup(cf(1, 0, 0, 2, 0, 4));
      lvl[4] <= 1'b1;
      watch(5);
      shot(0, 0);
      shot(0, 4);
   endtask

   // Two events skipped; requalification restarts the count in both variants
   task t_evs();
      wb(1'b1, `QDT_ADR_QEVS, 32'h2);
      for (int e = 0; e < 2; e++) begin
         setup(cf(1, e, 0, 3, 0, 4));
         lvl[4] <= 1'b1;
         watch(3);
         shot(0, 0);
         lvl[4] <= 1'b0;
         watch(3);
         lvl[4] <= 1'b1;
         watch(3);
         shot(0, 0);
         shot(0, 0);
         shot(0, 4);
      end
   endtask

   task t_edge_below();
      setup(cf(1, 1, 1, 0, 0, 4));
      lvl[4] <= 1'b1;
      watch(3);
      shot(0, 0);
      lvl[4] <= 1'b0;
      watch(3);
      lvl[4] <= 1'b1;
      watch(3);
      shot(0, 4);
   endtask

   task t_dropout();
      wb(1'b1, `QDT_ADR_DTIME, DT);
      setup(cf(2, 0, 0, 0, 5, 0));
      watch(20);
      chk(hit, 0);
      lvl[5] <= 1'b1;
      watch(6);
      chk(hit, 0);
      lvl[5] <= 1'b0;
      watch(2);
      lvl[5] <= 1'b1;
      watch(DT + 8);
      chk(hit, DT + 4);
      watch(20);
      chk(hit, 0);
      setup(cf(2, 0, 0, 0, 5, 0) | 32'h40);
      lvl[5] <= 1'b1;
      watch(DT + 8);
      chk(hit, 0);
      lvl[5] <= 1'b0;
      watch(DT + 8);
      chk(hit, DT + 4);
      // Thirteen triggers so far, nothing armed, qualifier level low
      rdchk(`QDT_ADR_STAT, 32'h000D0000);
   endtask

   // Main sequence
   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'hF;
      dat_i = 32'h0;
      lvl = 6'h00;
      fail_count = 0;
      n_compared = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_immediate();
      t_state_drop();
      t_tlimit();
      t_tdelay();
      t_evs();
      t_edge_below();
      t_dropout();
      finish_test();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      finish_test();
   end
endmodule
